//--- timer_defs.vh
// constants for the prescaled interval timer: register offsets, field positions, reset values
// assumes a 32-bit apb slave with 12 address bits, word aligned registers
//
// Contract
// - a 16-bit down-counter decrements by one every n processor cycles
// - software-writable 8-bit prescale register holds n
// - counter at zero raises a timer interrupt request toward the processor
// - counter at zero reloads from the 16-bit period register, repeating without software
// - timer expiry is one interrupt source beside serial, byte transfer and power-down
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define OFF_DOWN_COUNT 12'h000
`define OFF_PRESCALE 12'h004
`define OFF_PERIOD 12'h008
`define OFF_CONTROL 12'h00c
`define OFF_STATUS 12'h010
`define OFF_MASK 12'h014
`define OFF_EXPIRY_COUNT 12'h018

// ****************************************
// fields
// ****************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_LOAD_BIT 1
`define SRC_TIMER_BIT 0
`define SRC_SERIAL_BIT 1
`define SRC_BYTE_XFER_BIT 2
`define SRC_PWRDN_BIT 3
`define NUM_SOURCES 4

// ****************************************
// reset values
// ****************************************
`define RST_DOWN_COUNT 16'h0000
`define RST_PRESCALE 8'h01
`define RST_PERIOD 16'h0000
`define RST_CONTROL 2'h0
`define RST_MASK 4'h0

`endif

//--- cycle_prescaler.v
// cycle prescaler: one tick per n enabled clock cycles
// assumes scale is stable while running; a change is picked up at the next tick or restart
`timescale 1ns/1ps

module cycle_prescaler #(
    parameter WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire restart,
    input wire [WIDTH-1:0] scale,
    output wire tick
);

    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cnt_d;

    // n of zero behaves as one, so the counter can never stall
    assign tick = run && !restart && (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1});

    always @* begin
        cnt_d = cnt_q;
        if (!run || restart || tick) begin
            cnt_d = scale;
        end else begin
            cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= {WIDTH{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // cycle_prescaler

//--- prescaled_interval_timer.v
// prescaled interval timer with apb register access and a small interrupt status block
// assumes a single clock, synchronous one-cycle event inputs and a standard apb master
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "timer_defs.vh"

module prescaled_interval_timer #(
    parameter COUNT_W = 16,
    parameter SCALE_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire serial_evt,
    input wire byte_xfer_evt,
    input wire pwrdn_evt,
    output reg timer_req,
    output reg irq
);

    // ****************************************
    // state
    // ****************************************
    reg [COUNT_W-1:0] down_count_q;
    reg [COUNT_W-1:0] down_count_d;
    reg [SCALE_W-1:0] prescale_q;
    reg [COUNT_W-1:0] period_q;
    reg enable_q;
    reg load_q;
    reg [`NUM_SOURCES-1:0] status_q;
    reg [`NUM_SOURCES-1:0] mask_q;
    reg [`NUM_SOURCES-1:0] read_clr_q;
    reg [15:0] expiry_count_q;
    reg [31:0] rdata_d;
    reg addr_ok;

    wire access;
    wire wr_done;
    wire rd_done;
    wire capture;
    wire tick;
    wire expire;
    wire prescale_wr;
    wire [SCALE_W-1:0] scale_next;
    wire [`NUM_SOURCES-1:0] events;
    wire [`NUM_SOURCES-1:0] status_clr;

    // ****************************************
    // apb handshake
    // ****************************************
    // one wait state: read data and error come from flops, and the
    // read-clear acts only on bits the master actually saw
    assign access = psel && penable;
    assign capture = access && !pready;
    assign wr_done = access && pready && pwrite;
    assign rd_done = access && pready && !pwrite;

    always @* begin
        addr_ok = 1'b1;
        rdata_d = 32'h00000000;
        case (paddr)
            `OFF_DOWN_COUNT: begin
                rdata_d[COUNT_W-1:0] = down_count_q;
            end
            `OFF_PRESCALE: begin
                rdata_d[SCALE_W-1:0] = prescale_q;
            end
            `OFF_PERIOD: begin
                rdata_d[COUNT_W-1:0] = period_q;
            end
            `OFF_CONTROL: begin
                rdata_d[`CTRL_ENABLE_BIT] = enable_q;
            end
            `OFF_STATUS: begin
                rdata_d[`NUM_SOURCES-1:0] = status_q;
            end
            `OFF_MASK: begin
                rdata_d[`NUM_SOURCES-1:0] = mask_q;
            end
            `OFF_EXPIRY_COUNT: begin
                rdata_d[15:0] = expiry_count_q;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            read_clr_q <= {`NUM_SOURCES{1'b0}};
        end else begin
            pready <= capture;
            if (capture) begin
                pslverr <= !addr_ok;
                prdata <= pwrite ? 32'h00000000 : rdata_d;
                if (!pwrite && paddr == `OFF_STATUS) begin
                    read_clr_q <= status_q;
                end else begin
                    read_clr_q <= {`NUM_SOURCES{1'b0}};
                end
            end else begin
                pslverr <= 1'b0;
                read_clr_q <= {`NUM_SOURCES{1'b0}};
            end
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q <= `RST_PRESCALE;
            period_q <= `RST_PERIOD;
            enable_q <= 1'b0;
            load_q <= 1'b0;
            mask_q <= `RST_MASK;
        end else begin
            load_q <= 1'b0;
            if (wr_done) begin
                case (paddr)
                    `OFF_PRESCALE: begin
                        prescale_q <= pwdata[SCALE_W-1:0];
                    end
                    `OFF_PERIOD: begin
                        period_q <= pwdata[COUNT_W-1:0];
                    end
                    `OFF_CONTROL: begin
                        enable_q <= pwdata[`CTRL_ENABLE_BIT];
                        load_q <= pwdata[`CTRL_LOAD_BIT];
                    end
                    `OFF_MASK: begin
                        mask_q <= pwdata[`NUM_SOURCES-1:0];
                    end
                    default: begin
                        load_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // prescaler and down-counter
    // ****************************************
    // a new scale value restarts the prescaler so the old n never leaks into the next tick
    assign prescale_wr = wr_done && (paddr == `OFF_PRESCALE);
    // the register only updates at this edge, so the restart takes the written value directly
    assign scale_next = prescale_wr ? pwdata[SCALE_W-1:0] : prescale_q;

    cycle_prescaler #(
        .WIDTH(SCALE_W)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(enable_q),
        .restart(prescale_wr || load_q),
        .scale(scale_next),
        .tick(tick)
    );

    // zero is held for one tick interval, then the next tick reloads and expires
    assign expire = tick && (down_count_q == {COUNT_W{1'b0}});

    always @* begin
        down_count_d = down_count_q;
        if (wr_done && paddr == `OFF_DOWN_COUNT) begin
            down_count_d = pwdata[COUNT_W-1:0];
        end else if (load_q) begin
            down_count_d = period_q;
        end else if (expire) begin
            down_count_d = period_q;
        end else if (tick) begin
            down_count_d = down_count_q - {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            down_count_q <= `RST_DOWN_COUNT;
            expiry_count_q <= 16'h0000;
            timer_req <= 1'b0;
        end else begin
            down_count_q <= down_count_d;
            timer_req <= expire;
            if (expire) begin
                expiry_count_q <= expiry_count_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // interrupt sources
    // ****************************************
    assign events[`SRC_TIMER_BIT] = expire;
    assign events[`SRC_SERIAL_BIT] = serial_evt;
    assign events[`SRC_BYTE_XFER_BIT] = byte_xfer_evt;
    assign events[`SRC_PWRDN_BIT] = pwrdn_evt;
    assign status_clr = rd_done ? read_clr_q : {`NUM_SOURCES{1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SOURCES; gi = gi + 1) begin : g_src
            // set beats clear so an event landing on the read is kept
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_q[gi] <= 1'b0;
                end else if (events[gi]) begin
                    status_q[gi] <= 1'b1;
                end else if (status_clr[gi]) begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

endmodule // prescaled_interval_timer

//--- timer_monitor.sv
// port checker for the prescaled interval timer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "timer_defs.vh"

module timer_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire serial_evt,
    input wire byte_xfer_evt,
    input wire pwrdn_evt,
    input wire timer_req,
    input wire irq
);
    // ****************************************
    // shadow of programmed values
    // ****************************************
    logic [7:0] scale_q;
    logic [15:0] per_q;
    logic en_q;
    logic clean_q;
    logic [23:0] gap_q;
    logic [3:0] since_q;
    wire wr = psel && penable && pready && pwrite && !pslverr;
    wire cause = timer_req || serial_evt || byte_xfer_evt || pwrdn_evt || wr;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scale_q <= 8'h01;
            per_q <= 16'h0000;
            en_q <= 1'b0;
            clean_q <= 1'b0;
            gap_q <= 24'h000000;
            since_q <= 4'h0;
        end else begin
            if (wr && paddr == `OFF_PRESCALE) scale_q <= pwdata[7:0];
            if (wr && paddr == `OFF_PERIOD) per_q <= pwdata[15:0];
            if (wr && paddr == `OFF_CONTROL) en_q <= pwdata[0];
            // any write may disturb the interval, so only a clean gap is judged
            clean_q <= wr ? 1'b0 : (timer_req ? 1'b1 : clean_q);
            // wide enough for the longest interval, 65536 ticks of 255 cycles
            gap_q <= timer_req ? 24'h000001 : gap_q + 24'h000001;
            since_q <= cause ? 4'h0 : (since_q == 4'hf ? since_q : since_q + 4'h1);
        end
    end

    // ****************************************
    // properties
    // ****************************************
    property p_wait_state;
        @(posedge pclk) disable iff (!presetn) psel && penable && !pready |=> pready;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("ready not one cycle after access");
    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn) pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held two cycles");
    property p_err_decode;
        @(posedge pclk) disable iff (!presetn)
            pslverr |-> pready && (paddr > `OFF_EXPIRY_COUNT || paddr[1:0] != 2'h0);
    endproperty
    a_err_decode: assert property (p_err_decode) else $error("error on mapped address");
    property p_scale_read;
        @(posedge pclk) disable iff (!presetn)
            pready && !pwrite && paddr == `OFF_PRESCALE |-> prdata == {24'h000000, scale_q};
    endproperty
    a_scale_read: assert property (p_scale_read) else $error("prescale readback wrong");
    property p_period_read;
        @(posedge pclk) disable iff (!presetn)
            pready && !pwrite && paddr == `OFF_PERIOD |-> prdata == {16'h0000, per_q};
    endproperty
    a_period_read: assert property (p_period_read) else $error("period readback wrong");
    property p_req_enabled;
        @(posedge pclk) disable iff (!presetn) timer_req |-> en_q || $past(en_q);
    endproperty
    a_req_enabled: assert property (p_req_enabled) else $error("request while stopped");
    property p_spacing;
        @(posedge pclk) disable iff (!presetn)
            timer_req && clean_q |-> gap_q == (per_q + 24'h1) * (scale_q == 8'h00 ? 24'h1 : scale_q);
    endproperty
    a_spacing: assert property (p_spacing) else $error("expiry interval wrong");
    property p_irq_cause;
        @(posedge pclk) disable iff (!presetn) $rose(irq) |-> since_q <= 4'h4;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without a source");
endmodule // timer_monitor

//--- prescaled_interval_timer_test.sv
// self-checking bench for the prescaled interval timer over apb
// assumes the design files and timer_defs.vh are compiled first
`timescale 1ns/1ps
`include "timer_defs.vh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module prescaled_interval_timer_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic serial_evt = 0, byte_xfer_evt = 0, pwrdn_evt = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic er;
    wire [31:0] prdata;
    wire pready, pslverr, timer_req, irq;
    int fail_count = 0, check_count = 0, req_total = 0, g;
    // prescale, period, expected cycles between expiries
    int tbl[5][3] = '{'{2, 1, 4}, '{3, 2, 9}, '{255, 0, 255}, '{0, 2, 3}, '{1, 0, 1}};
    always #50 pclk = ~pclk;
    always @(posedge pclk) if (timer_req === 1'b1) req_total++;
    prescaled_interval_timer prescaled_interval_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_evt(serial_evt), .byte_xfer_evt(byte_xfer_evt), .pwrdn_evt(pwrdn_evt),
        .timer_req(timer_req), .irq(irq));

    // ****************************************
    // tasks
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata; er = pslverr;
        if (n >= 20) fail_count++;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
        `CHK("no error", 1'b0, er)
    endtask
    // skips the first, possibly shortened, interval
    task automatic gap_measure;
        g = 0;
        while (timer_req !== 1'b1 && g < 2000) begin @(posedge pclk); g++; end
        g = 0;
        do begin @(posedge pclk); g++; end while (timer_req !== 1'b1 && g < 2000);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`OFF_DOWN_COUNT, 32'h0, "count reset");
        rchk(`OFF_PRESCALE, 32'h1, "prescale reset");
        rchk(`OFF_PERIOD, 32'h0, "period reset");
        apb(1'b1, `OFF_PRESCALE, 32'hffffffff);
        rchk(`OFF_PRESCALE, 32'hff, "prescale width");
        apb(1'b1, `OFF_DOWN_COUNT, 32'h12345678);
        rchk(`OFF_DOWN_COUNT, 32'h5678, "count width");
        apb(1'b0, 12'h01c, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        apb(1'b1, 12'h01c, 32'h5);
        `CHK("unmapped write error", 1'b1, er)
        apb(1'b1, `OFF_MASK, 32'h1);
        foreach (tbl[i]) begin
            apb(1'b1, `OFF_CONTROL, 32'h0);
            apb(1'b1, `OFF_PRESCALE, tbl[i][0]);
            apb(1'b1, `OFF_PERIOD, tbl[i][1]);
            apb(1'b1, `OFF_CONTROL, 32'h3);
            gap_measure();
            `CHK("expiry gap", tbl[i][2], g)
        end
        @(posedge pclk);
        `CHK("timer irq", 1'b1, irq)
        apb(1'b1, `OFF_CONTROL, 32'h0);
        rchk(`OFF_STATUS, 32'h1, "timer status");
        rchk(`OFF_STATUS, 32'h0, "status cleared");
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        rchk(`OFF_EXPIRY_COUNT, {16'h0, req_total[15:0]}, "expiry count");
        for (int k = 1; k < 4; k++) begin
            serial_evt <= (k == 1); byte_xfer_evt <= (k == 2); pwrdn_evt <= (k == 3);
            @(posedge pclk);
            {serial_evt, byte_xfer_evt, pwrdn_evt} <= 3'b000;
            apb(1'b1, `OFF_MASK, 32'h1 << k);
            rchk(`OFF_MASK, 32'h1 << k, "mask readback");
            @(posedge pclk);
            `CHK("event irq", 1'b1, irq)
            rchk(`OFF_STATUS, 32'h1 << k, "event status");
            repeat (2) @(posedge pclk);
            `CHK("event irq cleared", 1'b0, irq)
        end
        // reset in mid-run, with the timer expiring every cycle
        apb(1'b1, `OFF_CONTROL, 32'h3);
        rchk(`OFF_CONTROL, 32'h1, "enable readback");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`OFF_CONTROL, 32'h0, "enable after reset");
        rchk(`OFF_PRESCALE, 32'h1, "prescale after reset");
        rchk(`OFF_EXPIRY_COUNT, 32'h0, "expiry count after reset");
        `CHK("irq after reset", 1'b0, irq)
        tally_and_finish();
    end
    // a hang past this is a failure
    initial begin
        #3000000;
        fail_count++;
        tally_and_finish();
    end
endmodule // prescaled_interval_timer_test

bind prescaled_interval_timer timer_monitor timer_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_evt(serial_evt), .byte_xfer_evt(byte_xfer_evt), .pwrdn_evt(pwrdn_evt),
    .timer_req(timer_req), .irq(irq));
